// ### ascr_defines.vh
// command codes, bit positions, reset values and timing for the command register bank
`ifndef ASCR_DEFINES_VH
`define ASCR_DEFINES_VH
`define ASCR_CMD_CS_WR        8'h82
`define ASCR_CMD_CS_RD        8'h83
`define ASCR_CMD_UNLOCK_WR    8'h94
`define ASCR_CMD_TC_WR        8'h96
`define ASCR_CMD_TC_RD        8'h97
`define ASCR_UNLOCK_VALUE     16'h16f4
`define ASCR_BIT_DIAG_ACTIVE  15
`define ASCR_BIT_DIAG_OVR     14
`define ASCR_BIT_UNDERVOLT    12
`define ASCR_BIT_CP_GATE      11
`define ASCR_BIT_SINGLE_FIX   8
`define ASCR_BIT_DOUBLE_FLT   7
`define ASCR_BIT_MAGNET_MISS  6
`define ASCR_BIT_CRC_BAD      4
`define ASCR_BIT_WRITE_EN     11
`define ASCR_RST_DIAG_OVR     1'b0
`define ASCR_RST_CP_GATE      1'b0
`define ASCR_RST_WRITE_EN     1'b0
`define ASCR_ENTRY_WINDOW_US  30
`define ASCR_CLK_MHZ          250
`define ASCR_ENTRY_CYCLES     (`ASCR_ENTRY_WINDOW_US * `ASCR_CLK_MHZ)
`endif

// ### ascr_command_regs.v
// command register bank of one sensor channel behind the one-wire link
// Behaviour
// - unlock accepted only inside entry window or in diagnostic mode; write-only
// - decode commands 82h/83h, 94h, 96h/97h
// - bit 15 shows diagnostic, ignores override
// - bit 14 forces diagnostic output off, resets 0
// - bit 12 shows undervoltage detected
// - bit 11 gates charge pump clock, only while test control write enable is set
// - bit 8 sticky corrected single-bit error
// - bit 7 sticky uncorrectable double-bit error
// - bit 6 sticky magnet loss
// - bit 4 checksum mismatch, start-up evaluated
// - test control bit 11 is write enable
`timescale 1ns/10ps
`include "ascr_defines.vh"
// the link layer hands over one strobe per whole access, direction already known;
// bit timing, the memory array and the checksum engine live outside this bank;
// the sticky flags only ever set here, so a cleared condition still needs a
// power-on reset before the flag drops, which keeps a past fault visible
module ascr_command_regs #(
  parameter ENTRY_CYCLES = `ASCR_ENTRY_CYCLES
) (
  // clock and raw power-on reset
  input  wire        mclk_i,
  input  wire        rst_n_i,
  // decoded accesses from the link
  input  wire        cmd_valid_i,      // one-cycle strobe: decoded access from the link
  input  wire [7:0]  cmd_code_i,
  input  wire [15:0] cmd_wdata_i,
  // memory readout and start-up checksum events
  input  wire        mem_readout_i,    // one-cycle strobe at each memory readout
  input  wire        mem_single_fix_i,
  input  wire        mem_double_flt_i,
  input  wire        crc_done_i,       // one-cycle strobe at start-up checksum result
  input  wire        crc_bad_i,
  // analog monitors and other diagnostic sources
  input  wire        undervoltage_i,   // pin-domain level
  input  wire        magnet_missing_i, // pin-domain level
  input  wire        magnet_det_en_i,
  input  wire        diag_other_i,     // other diagnostic sources
  // read answer
  output reg  [15:0] rd_data_o,
  output reg         rd_valid_o,
  // mode and control levels
  output wire        command_mode_o,
  output wire        diagnostic_active_o,
  output wire        diag_output_o,
  output wire        charge_pump_clock_gate_o,
  output wire        nv_write_en_o
);
  // reset synchroniser
  reg         rst_s1_q;
  reg         rst_s2_q;
  wire        rst_n;

  // pin synchronisers and settled levels
  reg  [2:0]  uv_sync_q;
  reg  [2:0]  ml_sync_q;
  reg         uv_q;
  reg         ml_q;

  // entry window and command mode
  reg         unlocked_q;
  reg  [31:0] entry_cnt_q;
  wire        window_open;
  wire        sig_match;

  // writable fields
  reg         diag_ovr_q;
  reg         cp_gate_q;
  reg         write_en_q;

  // sticky fault flags and the checksum result
  reg         single_fix_q;
  reg         double_flt_q;
  reg         magnet_miss_q;
  reg         crc_bad_q;

  // decode and read path
  wire        wr_ok;
  wire        hit_cs_wr;
  wire        hit_cs_rd;
  wire        hit_unlock;
  wire        hit_tc_wr;
  wire        hit_tc_rd;
  wire        rd_hit;
  wire [15:0] cs_word;
  wire [15:0] tc_word;
  reg  [15:0] rd_mux;

  // true when a strobed access carries the given command byte
  function cmd_is;
    input       valid;
    input [7:0] code;
    input [7:0] want;
    begin
      cmd_is = valid && (code == want);
    end
  endfunction

  // a pin level moves only once the second and third stage agree
  function settle;
    input [2:0] chain;
    input       held;
    begin
      settle = (chain[1] == chain[2]) ? chain[2] : held;
    end
  endfunction

  // one field bit of a written word
  function field_bit;
    input [15:0] word;
    input integer pos;
    begin
      field_bit = word[pos];
    end
  endfunction

  // a sticky flag keeps its value and only ever sets
  function sticky_next;
    input flag;
    input set;
    begin
      sticky_next = flag || set;
    end
  endfunction

  // reset released through two flops so every flop leaves reset on one edge
  always @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rst_s1_q <= 1'b0;
      rst_s2_q <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_s2_q <= rst_s1_q;
    end
  end
  assign rst_n = rst_s2_q;

  // undervoltage pin through three flops; a one-cycle glitch never counts
  always @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      uv_sync_q <= 3'h0;
      uv_q      <= 1'b0;
    end else begin
      uv_sync_q <= {uv_sync_q[1:0], undervoltage_i};
      uv_q      <= settle(uv_sync_q, uv_q);
    end
  end

  // magnet pin through three flops, same filtering as the supply monitor
  always @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      ml_sync_q <= 3'h0;
      ml_q      <= 1'b0;
    end else begin
      ml_sync_q <= {ml_sync_q[1:0], magnet_missing_i};
      ml_q      <= settle(ml_sync_q, ml_q);
    end
  end

  // entry window counts from reset release and then stops, so it never wraps
  always @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n)
      entry_cnt_q <= 32'h0;
    else if (entry_cnt_q < ENTRY_CYCLES)
      entry_cnt_q <= entry_cnt_q + 32'h1;
  end
  // afterwards only diagnostic mode reopens the window
  assign window_open = (entry_cnt_q < ENTRY_CYCLES) || diagnostic_active_o;

  // unlock needs the exact signature; the register has no read side
  assign sig_match  = (cmd_wdata_i == `ASCR_UNLOCK_VALUE);
  assign hit_unlock = cmd_is(cmd_valid_i, cmd_code_i, `ASCR_CMD_UNLOCK_WR);
  always @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n)
      unlocked_q <= 1'b0;
    else if (hit_unlock && sig_match && window_open)
      unlocked_q <= 1'b1;
  end
  // command mode holds until the next power-on reset
  assign command_mode_o = unlocked_q;

  // register accesses count only in command mode; the link delivers whole words
  assign wr_ok     = cmd_valid_i && unlocked_q;
  assign hit_cs_wr = cmd_is(wr_ok, cmd_code_i, `ASCR_CMD_CS_WR);
  assign hit_cs_rd = cmd_is(wr_ok, cmd_code_i, `ASCR_CMD_CS_RD);
  assign hit_tc_wr = cmd_is(wr_ok, cmd_code_i, `ASCR_CMD_TC_WR);
  assign hit_tc_rd = cmd_is(wr_ok, cmd_code_i, `ASCR_CMD_TC_RD);

  // diagnostic override; reserved bits of the written word are dropped
  always @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n)
      diag_ovr_q <= `ASCR_RST_DIAG_OVR;
    else if (hit_cs_wr)
      diag_ovr_q <= field_bit(cmd_wdata_i, `ASCR_BIT_DIAG_OVR);
  end

  // charge pump clock request bit
  always @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n)
      cp_gate_q <= `ASCR_RST_CP_GATE;
    else if (hit_cs_wr)
      cp_gate_q <= field_bit(cmd_wdata_i, `ASCR_BIT_CP_GATE);
  end

  // non-volatile write enable in the test control word
  always @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n)
      write_en_q <= `ASCR_RST_WRITE_EN;
    else if (hit_tc_wr)
      write_en_q <= field_bit(cmd_wdata_i, `ASCR_BIT_WRITE_EN);
  end

  // pump clock runs only with the write enable also set, guarding the nv array
  assign charge_pump_clock_gate_o = cp_gate_q && write_en_q;
  assign nv_write_en_o            = write_en_q;

  // corrected single-bit error, judged at each memory readout
  always @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n)
      single_fix_q <= 1'b0;
    else
      single_fix_q <= sticky_next(single_fix_q, mem_readout_i && mem_single_fix_i);
  end

  // uncorrectable double-bit error, judged at each memory readout
  always @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n)
      double_flt_q <= 1'b0;
    else
      double_flt_q <= sticky_next(double_flt_q, mem_readout_i && mem_double_flt_i);
  end

  // magnet loss counts only while detection is enabled
  always @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n)
      magnet_miss_q <= 1'b0;
    else
      magnet_miss_q <= sticky_next(magnet_miss_q, ml_q && magnet_det_en_i);
  end

  // checksum result follows each start-up evaluation
  always @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n)
      crc_bad_q <= 1'b0;
    else if (crc_done_i)
      crc_bad_q <= crc_bad_i;
  end

  // diagnostic state ignores the override; override only silences the output
  assign diagnostic_active_o = magnet_miss_q || double_flt_q || crc_bad_q ||
                               uv_q || diag_other_i;
  assign diag_output_o = diagnostic_active_o && !diag_ovr_q;

  // control/status read word; reserved bits tied low
  assign cs_word[`ASCR_BIT_DIAG_ACTIVE] = diagnostic_active_o;
  assign cs_word[`ASCR_BIT_DIAG_OVR]    = diag_ovr_q;
  assign cs_word[13]                    = 1'b0;
  assign cs_word[`ASCR_BIT_UNDERVOLT]   = uv_q;
  assign cs_word[`ASCR_BIT_CP_GATE]     = cp_gate_q;
  assign cs_word[10:9]                  = 2'b00;
  assign cs_word[`ASCR_BIT_SINGLE_FIX]  = single_fix_q;
  assign cs_word[`ASCR_BIT_DOUBLE_FLT]  = double_flt_q;
  assign cs_word[`ASCR_BIT_MAGNET_MISS] = magnet_miss_q;
  assign cs_word[5]                     = 1'b0;
  assign cs_word[`ASCR_BIT_CRC_BAD]     = crc_bad_q;
  assign cs_word[3:0]                   = 4'h0;

  // test control read word; only the write enable is implemented
  assign tc_word[15:12]                 = 4'h0;
  assign tc_word[`ASCR_BIT_WRITE_EN]    = write_en_q;
  assign tc_word[10:0]                  = 11'h000;

  // read word chosen by command; unknown codes give zero
  always @* begin
    rd_mux = 16'h0000;
    case (cmd_code_i)
      `ASCR_CMD_CS_RD: rd_mux = cs_word;
      `ASCR_CMD_TC_RD: rd_mux = tc_word;
      default:         rd_mux = 16'h0000;
    endcase
  end
  // the unlock code never reaches the read path
  assign rd_hit = hit_cs_rd || hit_tc_rd;

  // read answer one cycle after the command; data holds until the next read
  always @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      rd_data_o  <= 16'h0000;
      rd_valid_o <= 1'b0;
    end else begin
      rd_valid_o <= rd_hit;
      if (rd_hit)
        rd_data_o <= rd_mux;
    end
  end
endmodule // ascr_command_regs

// ### ascr_chk.sv
// assertions on the command register bank ports
`timescale 1ns/10ps
module ascr_chk (
  input wire        mclk_i,
  input wire        rst_n_i,
  input wire        cmd_valid_i,
  input wire [7:0]  cmd_code_i,
  input wire [15:0] cmd_wdata_i,
  input wire [15:0] rd_data_o,
  input wire        rd_valid_o,
  input wire        command_mode_o,
  input wire        diag_output_o,
  input wire        charge_pump_clock_gate_o,
  input wire        nv_write_en_o
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!rst_n_i);
  // accesses that the bank acts on, and the unlock pattern
  wire ok  = cmd_valid_i & command_mode_o;
  wire sig = cmd_valid_i && cmd_code_i == 8'h94 && cmd_wdata_i == 16'h16f4;
  read_ans_a: assert property (ok && cmd_code_i inside {8'h83, 8'h97} |=> rd_valid_o)
    else $error("read not answered");
  locked_a: assert property (cmd_valid_i && !command_mode_o |=> !rd_valid_o)
    else $error("answer while locked");
  sig_noread_a: assert property (cmd_valid_i && cmd_code_i == 8'h94 |=> !rd_valid_o)
    else $error("signature readable");
  unlock_a: assert property ($rose(command_mode_o) |-> $past(sig))
    else $error("unlock without signature");
  wen_a: assert property (ok && cmd_code_i == 8'h96 |=> nv_write_en_o == $past(cmd_wdata_i[11]))
    else $error("write enable not stored");
  ovr_a: assert property (ok && cmd_code_i == 8'h82 && cmd_wdata_i[14] |=> !diag_output_o)
    else $error("override ignored");
  cp_a: assert property (ok && cmd_code_i == 8'h82 |=>
    charge_pump_clock_gate_o == ($past(cmd_wdata_i[11]) & nv_write_en_o))
    else $error("charge pump gate wrong");
  rsv_a: assert property (rd_valid_o |-> (rd_data_o & 16'h262f) == 16'h0000)
    else $error("reserved bit set");
  cover property ($rose(command_mode_o));
  cover property (rd_valid_o);
  cover property (charge_pump_clock_gate_o);
endmodule // ascr_chk
bind ascr_command_regs ascr_chk u_chk (.mclk_i(mclk_i), .rst_n_i(rst_n_i),
  .cmd_valid_i(cmd_valid_i), .cmd_code_i(cmd_code_i), .cmd_wdata_i(cmd_wdata_i),
  .rd_data_o(rd_data_o), .rd_valid_o(rd_valid_o), .command_mode_o(command_mode_o),
  .diag_output_o(diag_output_o), .charge_pump_clock_gate_o(charge_pump_clock_gate_o),
  .nv_write_en_o(nv_write_en_o));

// ### ascr_owi_master.sv
// link master model handing whole accesses to the bank
`timescale 1ns/10ps
module ascr_owi_master (
  input  wire        mclk_i,
  output reg         v_o = 1'b0,
  output reg  [7:0]  c_o = 8'h00,
  output reg  [15:0] d_o = 16'h0000
);
  // command and word travel together; released data flips so stale words never match
  task xfer(input [7:0] cc, input [15:0] dd);
    begin
      @(posedge mclk_i);
      v_o <= 1'b1;
      c_o <= cc;
      d_o <= dd;
      @(posedge mclk_i);
      v_o <= 1'b0;
      d_o <= ~dd;
    end
  endtask
endmodule // ascr_owi_master

// ### angle_sensor_command_registers_tb.sv
// self-checking bench for the command register bank
`timescale 1ns/10ps
module angle_sensor_command_registers_tb;
  reg         mclk = 1'b0;
  reg         rst_n = 1'b0;
  reg  [8:0]  x = 9'h000;
  reg  [15:0] r, w, u;
  wire        v, cm, da, dout, cpg, we, rv;
  wire [7:0]  c;
  wire [15:0] d, rdat;
  integer     fails = 0, tests_run = 0, cyc = 0, i;
  initial forever #2 mclk = ~mclk;
  ascr_owi_master u_m (.mclk_i(mclk), .v_o(v), .c_o(c), .d_o(d));
  ascr_command_regs #(.ENTRY_CYCLES(20)) u_dut (.mclk_i(mclk), .rst_n_i(rst_n),
    .cmd_valid_i(v), .cmd_code_i(c), .cmd_wdata_i(d), .mem_readout_i(x[0]),
    .mem_single_fix_i(x[1]), .mem_double_flt_i(x[2]), .crc_done_i(x[3]), .crc_bad_i(x[4]),
    .undervoltage_i(x[5]), .magnet_missing_i(x[6]), .magnet_det_en_i(x[7]),
    .diag_other_i(x[8]), .rd_data_o(rdat), .rd_valid_o(rv), .command_mode_o(cm),
    .diagnostic_active_o(da), .diag_output_o(dout), .charge_pump_clock_gate_o(cpg),
    .nv_write_en_o(we));
  task cmp(input string n, input [15:0] e, input [15:0] s);
    begin
      tests_run = tests_run + 1;
      if (s !== e) begin
        fails = fails + 1;
        $display("[FAIL] %0s exp %h got %h", n, e, s);
      end
    end
  endtask
  // expected control/status word: override and pump bits, diagnostic from outside
  function automatic [15:0] exp_cs(input [15:0] wr, input dg);
    exp_cs = (wr & 16'h4800) | {dg, 15'h0000};
  endfunction
  // a missing answer shows as dead so it cannot pass for data
  task rd(input [7:0] cc, input [15:0] m, input [15:0] e, input string n);
    begin
      u_m.xfer(cc, 16'h0000);
      #1;
      r = (rv === 1'b1) ? rdat : 16'hdead;
      cmp(n, e & m, r & m);
    end
  endtask
  task rs;
    begin
      rst_n <= 1'b0;
      repeat (5) @(posedge mclk);
      rst_n <= 1'b1;
      repeat (3) @(posedge mclk);
    end
  endtask
  task end_sim;
    begin
      $display("checks %0d mismatches %0d", tests_run, fails);
      if (fails == 0 && tests_run > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
    end
  endtask
  // hang guard, far above the roughly 150 cycles the run needs
  always @(posedge mclk) begin
    cyc = cyc + 1;
    if (cyc == 3000) begin
      fails = fails + 1;
      end_sim;
    end
  end
  initial begin
    void'($urandom(32'h32db3466));
    rs;
    repeat (30) @(posedge mclk);
    u_m.xfer(8'h94, 16'h16f4);
    #1 cmp("late unlock", 16'h0000, 16'(cm));
    rs;
    rd(8'h83, 16'hffff, 16'hdead, "locked read");
    u_m.xfer(8'h94, 16'h16f5);
    u_m.xfer(8'h94, 16'h16f4);
    #1 cmp("unlock", 16'h0001, 16'(cm));
    rd(8'h94, 16'hffff, 16'hdead, "sig read");
    rd(8'h97, 16'hffff, 16'h0000, "tc reset");
    for (i = 0; i < 8; i = i + 1) begin
      w = $urandom;
      u = $urandom;
      @(posedge mclk);
      x <= {u[0], 8'h00};
      u_m.xfer(8'h82, w);
      u_m.xfer(8'h96, u);
      rd(8'h83, 16'hffff, exp_cs(w, u[0]), "cs");
      cmp("nv wen", 16'(u[11]), 16'(we));
      rd(8'h97, 16'hffff, u & 16'h0800, "tc");
      cmp("cp gate", 16'(w[11] & u[11]), 16'(cpg));
      cmp("diag out", 16'(u[0] & ~w[14]), 16'(dout));
    end
    @(posedge mclk);
    x <= 9'h0c0;
    repeat (6) @(posedge mclk);
    #1 cmp("diag", 16'h0001, 16'(da));
    @(posedge mclk);
    x <= 9'h0ff;
    @(posedge mclk);
    x <= 9'h0e0;
    repeat (6) @(posedge mclk);
    x <= 9'h029;
    @(posedge mclk);
    x <= 9'h020;
    repeat (6) @(posedge mclk);
    rd(8'h83, 16'h11d0, 16'h11c0, "sticky");
    end_sim;
  end
endmodule // angle_sensor_command_registers_tb
